/* tde_pkg.sv */
// constants, field positions and carrier types for the timer and data-miss exception entry
package tde_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] OFF_TCR = 8'h00;
  localparam logic [7:0] OFF_TSR = 8'h04;
  localparam logic [7:0] OFF_MSR = 8'h08;
  localparam logic [7:0] OFF_SAVE_RESTORE_0 = 8'h0c;
  localparam logic [7:0] OFF_SAVE_RESTORE_1 = 8'h10;
  localparam logic [7:0] OFF_SAVE_RESTORE_2 = 8'h14;
  localparam logic [7:0] OFF_SAVE_RESTORE_3 = 8'h18;
  localparam logic [7:0] OFF_ESR = 8'h1c;
  localparam logic [7:0] OFF_DATA_FAULT_ADDRESS_REG = 8'h20;
  localparam logic [7:0] OFF_PID = 8'h24;
  localparam logic [7:0] OFF_TLB_IDX = 8'h28;
  localparam logic [7:0] OFF_TLB_DATA = 8'h2c;
  // machine_state_reg field positions
  localparam int MSR_AP = 25;
  localparam int MSR_APE = 19;
  localparam int MSR_WE = 18;
  localparam int MSR_CE = 17;
  localparam int MSR_EE = 15;
  localparam int MSR_PR = 14;
  localparam int MSR_FP = 13;
  localparam int MSR_ME = 12;
  localparam int MSR_FE0 = 11;
  localparam int MSR_DWE = 10;
  localparam int MSR_DE = 9;
  localparam int MSR_FE1 = 8;
  localparam int MSR_IR = 5;
  localparam int MSR_DR = 4;
  // bits cleared on noncritical entry, and on critical entry
  localparam logic [31:0] MSR_NC_CLR = (32'h1 << MSR_AP) | (32'h1 << MSR_APE) | (32'h1 << MSR_WE) |
    (32'h1 << MSR_EE) | (32'h1 << MSR_PR) | (32'h1 << MSR_FP) | (32'h1 << MSR_FE0) | (32'h1 << MSR_DWE) |
    (32'h1 << MSR_FE1) | (32'h1 << MSR_IR) | (32'h1 << MSR_DR);
  localparam logic [31:0] MSR_CR_CLR = MSR_NC_CLR | (32'h1 << MSR_CE) | (32'h1 << MSR_DE);
  // timer_status_reg and timer_control_reg fields
  localparam int TSR_ENW = 31;
  localparam int TSR_WIS = 30;
  localparam int TSR_FIS = 26;
  localparam logic [31:0] TSR_FLAGS = (32'h1 << TSR_WIS) | (32'h1 << TSR_FIS);
  localparam int TCR_WP = 30;
  localparam int TCR_WIE = 27;
  localparam int TCR_FP = 24;
  localparam int TCR_FIE = 23;
  // time-base bit for period code 0; each code step moves four bits up
  localparam int FIT_TB_BASE = 9;
  localparam int WDOG_TB_BASE = 17;
  localparam int TB_STEP = 4;
  // exception_syndrome_reg fields
  localparam int ESR_MCI = 31;
  localparam int ESR_DST = 23;
  // tlb data word fields
  localparam int TLBD_VALID = 31;
  localparam int TLBD_TID = 20;
  localparam int EPN_W = 20;
  localparam int TID_W = 8;
  // vector offsets
  localparam logic [15:0] VEC_FIT = 16'h1010;
  localparam logic [15:0] VEC_WDOG = 16'h1020;
  localparam logic [15:0] VEC_DTLB = 16'h1100;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  // a data access presented by the load/store pipe
  typedef struct packed {
    logic valid;
    logic store_like;
    logic [31:0] insn_addr;
    logic [31:0] addr;
  } tde_dacc_t;
  // one translation entry
  typedef struct packed {
    logic valid;
    logic [TID_W-1:0] entry_process_tag;
    logic [EPN_W-1:0] effective_page_number;
  } tde_tlbe_t;
endpackage

/* tde_exception_entry.sv */
// exception entry for fixed-interval timer, watchdog and data translation miss
`timescale 1ns/100ps
`default_nettype none

module tde_exception_entry #(
  parameter int TLB_N = 64
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic [31:0] time_base,
  input wire logic [31:0] next_insn_addr,
  input wire tde_pkg::tde_dacc_t dacc,
  // exception entry to the fetch unit
  output logic exc_take,
  output logic exc_critical,
  output logic [15:0] exc_vector,
  output logic [31:0] msr_out
);
  import tde_pkg::*;

  localparam int IDX_W = (TLB_N > 1) ? $clog2(TLB_N) : 1;

  logic [31:0] timer_control_reg, timer_status_reg, save_restore_0, save_restore_1, save_restore_2, save_restore_3, exception_syndrome_reg, data_fault_address_reg, tb_q;
  logic [TID_W-1:0] process_id;
  logic [IDX_W-1:0] tlb_index;
  logic wdog_det;
  tde_tlbe_t tlb [TLB_N];

  // picks the time-base bit that a two-bit period code selects
  function automatic logic tb_sel(input logic [31:0] tb, input logic [1:0] code, input int base);
    int idx;
    idx = base + TB_STEP * int'(code);
    return tb[idx[4:0]];
  endfunction

  // time-out edges on the selected time-base bits
  wire logic fit_now = tb_sel(time_base, timer_control_reg[TCR_FP +: 2], FIT_TB_BASE);
  wire logic fit_was = tb_sel(tb_q, timer_control_reg[TCR_FP +: 2], FIT_TB_BASE);
  wire logic wd_now = tb_sel(time_base, timer_control_reg[TCR_WP +: 2], WDOG_TB_BASE);
  wire logic wd_was = tb_sel(tb_q, timer_control_reg[TCR_WP +: 2], WDOG_TB_BASE);
  wire logic fit_edge = fit_now & ~fit_was;
  wire logic wd_edge = wd_now & ~wd_was;
  wire logic next_wdog_det = wd_edge & timer_status_reg[TSR_ENW] & ~timer_status_reg[TSR_WIS];

  // translation lookup, one comparator per entry
  logic [TLB_N-1:0] tlb_hit;
  genvar gi;
  generate
    for (gi = 0; gi < TLB_N; gi++) begin : g_cmp
      assign tlb_hit[gi] = tlb[gi].valid && tlb[gi].effective_page_number == dacc.addr[31 -: EPN_W] &&
        tlb[gi].entry_process_tag == process_id;
    end
  endgenerate
  wire logic dtlb_miss = ~|tlb_hit;

  // entry selection: the synchronous miss first, then watchdog, then fixed interval
  wire logic take_dtlb = dacc.valid & msr_out[MSR_DR] & dtlb_miss;
  wire logic take_wdog = ~take_dtlb & timer_status_reg[TSR_WIS] & timer_control_reg[TCR_WIE] & msr_out[MSR_CE];
  wire logic take_fit = ~take_dtlb & ~take_wdog & timer_status_reg[TSR_FIS] & timer_control_reg[TCR_FIE] & msr_out[MSR_EE];
  wire logic take_nc = take_dtlb | take_fit;
  wire logic take_any = take_nc | take_wdog;
  wire logic [15:0] next_vector = take_dtlb ? VEC_DTLB : (take_wdog ? VEC_WDOG : VEC_FIT);

  // apb address decode; transfer completes where pready is sampled high
  wire logic apb_done = psel & penable & pready;
  wire logic apb_wr = apb_done & pwrite;
  wire logic hit_tcr = paddr == OFF_TCR;
  wire logic hit_tsr = paddr == OFF_TSR;
  wire logic hit_msr = paddr == OFF_MSR;
  wire logic hit_save_restore_0 = paddr == OFF_SAVE_RESTORE_0;
  wire logic hit_save_restore_1 = paddr == OFF_SAVE_RESTORE_1;
  wire logic hit_save_restore_2 = paddr == OFF_SAVE_RESTORE_2;
  wire logic hit_save_restore_3 = paddr == OFF_SAVE_RESTORE_3;
  wire logic hit_esr = paddr == OFF_ESR;
  wire logic hit_data_fault_address_reg = paddr == OFF_DATA_FAULT_ADDRESS_REG;
  wire logic hit_pid = paddr == OFF_PID;
  wire logic hit_tidx = paddr == OFF_TLB_IDX;
  wire logic hit_tdat = paddr == OFF_TLB_DATA;
  wire logic addr_ok = hit_tcr | hit_tsr | hit_msr | hit_save_restore_0 | hit_save_restore_1 | hit_save_restore_2 | hit_save_restore_3 |
    hit_esr | hit_data_fault_address_reg | hit_pid | hit_tidx | hit_tdat;
  wire tde_tlbe_t tlb_sel = tlb[tlb_index];
  wire logic [31:0] tlb_word = {tlb_sel.valid, 3'h0, tlb_sel.entry_process_tag, tlb_sel.effective_page_number};
  wire logic [31:0] rd_val = hit_tcr ? timer_control_reg : hit_tsr ? timer_status_reg : hit_msr ? msr_out :
    hit_save_restore_0 ? save_restore_0 : hit_save_restore_1 ? save_restore_1 : hit_save_restore_2 ? save_restore_2 : hit_save_restore_3 ? save_restore_3 :
    hit_esr ? exception_syndrome_reg : hit_data_fault_address_reg ? data_fault_address_reg : hit_pid ? {{(32-TID_W){1'b0}}, process_id} :
    hit_tidx ? {{(32-IDX_W){1'b0}}, tlb_index} : hit_tdat ? tlb_word : RST_WORD;

  // next register values; an entry wins over a software write in the same cycle
  wire logic [31:0] tsr_sw = apb_wr & hit_tsr ? ((timer_status_reg & TSR_FLAGS & ~pwdata) | (pwdata & ~TSR_FLAGS)) : timer_status_reg;
  wire logic [31:0] next_tsr = tsr_sw | (fit_edge ? (32'h1 << TSR_FIS) : RST_WORD) |
    (wdog_det ? (32'h1 << TSR_WIS) : RST_WORD);
  wire logic [31:0] next_msr = take_nc ? (msr_out & ~MSR_NC_CLR) :
    take_wdog ? (msr_out & ~MSR_CR_CLR) :
    (apb_wr & hit_msr) ? pwdata : msr_out;
  wire logic [31:0] next_save_restore_0 = take_fit ? next_insn_addr :
    take_dtlb ? dacc.insn_addr :
    (apb_wr & hit_save_restore_0) ? pwdata : save_restore_0;
  wire logic [31:0] next_save_restore_1 = take_nc ? msr_out : (apb_wr & hit_save_restore_1) ? pwdata : save_restore_1;
  wire logic [31:0] next_save_restore_2 = take_wdog ? next_insn_addr : (apb_wr & hit_save_restore_2) ? pwdata : save_restore_2;
  wire logic [31:0] next_save_restore_3 = take_wdog ? msr_out : (apb_wr & hit_save_restore_3) ? pwdata : save_restore_3;
  wire logic [31:0] next_esr = take_dtlb ? ((exception_syndrome_reg & (32'h1 << ESR_MCI)) |
    (dacc.store_like ? (32'h1 << ESR_DST) : RST_WORD)) :
    (apb_wr & hit_esr) ? pwdata : exception_syndrome_reg;
  wire logic [31:0] next_data_fault_address_reg = take_dtlb ? dacc.addr : (apb_wr & hit_data_fault_address_reg) ? pwdata : data_fault_address_reg;

  // timer_control_reg, written by software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg <= RST_WORD;
    end else begin
      timer_control_reg <= (apb_wr & hit_tcr) ? pwdata : timer_control_reg;
    end
  end

  // timer_status_reg: flags set by time-outs, cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_status_reg <= RST_WORD;
    end else begin
      timer_status_reg <= next_tsr;
    end
  end

  // machine_state_reg, trimmed on every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_out <= RST_WORD;
    end else begin
      msr_out <= next_msr;
    end
  end

  // return address for noncritical entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_restore_0 <= RST_WORD;
    end else begin
      save_restore_0 <= next_save_restore_0;
    end
  end

  // saved state for noncritical entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_restore_1 <= RST_WORD;
    end else begin
      save_restore_1 <= next_save_restore_1;
    end
  end

  // return address for critical entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_restore_2 <= RST_WORD;
    end else begin
      save_restore_2 <= next_save_restore_2;
    end
  end

  // saved state for critical entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_restore_3 <= RST_WORD;
    end else begin
      save_restore_3 <= next_save_restore_3;
    end
  end

  // syndrome of the last data miss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exception_syndrome_reg <= RST_WORD;
    end else begin
      exception_syndrome_reg <= next_esr;
    end
  end

  // address of the last failed data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_fault_address_reg <= RST_WORD;
    end else begin
      data_fault_address_reg <= next_data_fault_address_reg;
    end
  end

  // time-base copy from the previous edge, for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_q <= RST_WORD;
    end else begin
      tb_q <= time_base;
    end
  end

  // watchdog detect stage; the flag follows one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_det <= 1'b0;
    end else begin
      wdog_det <= next_wdog_det;
    end
  end

  // process id and translation table, loaded through index and data words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_id <= '0;
      tlb_index <= '0;
      for (int i = 0; i < TLB_N; i++) begin
        tlb[i] <= '0;
      end
    end else begin
      if (apb_wr & hit_pid) begin
        process_id <= pwdata[TID_W-1:0];
      end
      if (apb_wr & hit_tidx) begin
        tlb_index <= pwdata[IDX_W-1:0];
      end
      if (apb_wr & hit_tdat) begin
        tlb[tlb_index] <= {pwdata[TLBD_VALID], pwdata[TLBD_TID +: TID_W], pwdata[EPN_W-1:0]};
      end
    end
  end

  // exception entry outputs, one cycle per entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_take <= 1'b0;
      exc_critical <= 1'b0;
      exc_vector <= VEC_FIT;
    end else begin
      exc_take <= take_any;
      exc_critical <= take_wdog;
      exc_vector <= next_vector;
    end
  end

  // apb ready: one wait state, high in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // apb read data, zero outside a read answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_WORD;
    end else begin
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_val : RST_WORD;
    end
  end

  // apb error for an address that maps to no register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~addr_ok;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wdog_arm;
    wd_edge && timer_status_reg[TSR_ENW] && !timer_status_reg[TSR_WIS];
  endsequence
  sequence s_wdog_flag;
    !timer_status_reg[TSR_WIS] ##1 timer_status_reg[TSR_WIS];
  endsequence
  sequence s_fit_ready;
    timer_status_reg[TSR_FIS] && timer_control_reg[TCR_FIE] && msr_out[MSR_EE] && !take_dtlb && !take_wdog;
  endsequence
  sequence s_fit_enabled;
    timer_control_reg[TCR_FIE] && msr_out[MSR_EE] && !take_dtlb && !take_wdog;
  endsequence
  sequence s_wdog_enabled;
    timer_control_reg[TCR_WIE] && msr_out[MSR_CE] && !take_dtlb;
  endsequence

  a_fit_flag_set: assert property (fit_edge |=> timer_status_reg[TSR_FIS])
    else $error("interval flag not set after time-out");
  a_fit_entry_vec: assert property (s_fit_ready |=> exc_take && !exc_critical && exc_vector == VEC_FIT)
    else $error("fixed-interval entry missing or wrong vector");
  a_fit_gate_enables: assert property (take_fit |-> timer_control_reg[TCR_FIE] && msr_out[MSR_EE])
    else $error("fixed-interval taken while disabled");
  a_nc_save_state: assert property (take_nc && !(apb_wr && (hit_save_restore_2 || hit_save_restore_3)) |=>
    save_restore_1 == $past(msr_out) && save_restore_2 == $past(save_restore_2) && save_restore_3 == $past(save_restore_3))
    else $error("noncritical save registers wrong");
  a_fit_save_addr: assert property (take_fit |=> save_restore_0 == $past(next_insn_addr))
    else $error("fixed-interval return address wrong");
  a_nc_msr_clear: assert property (take_nc |=> (msr_out & MSR_NC_CLR) == 32'h0 &&
    (msr_out & ~MSR_NC_CLR) == ($past(msr_out) & ~MSR_NC_CLR))
    else $error("noncritical state update wrong");
  a_wdog_flag_seq: assert property (s_wdog_arm |=> s_wdog_flag)
    else $error("watchdog flag timing wrong");
  a_wdog_flag_block: assert property (wd_edge && timer_status_reg[TSR_WIS] |=> !wdog_det)
    else $error("watchdog re-detected while flag set");
  a_wdog_entry_vec: assert property (take_wdog |-> timer_control_reg[TCR_WIE] && msr_out[MSR_CE] ##1
    exc_take && exc_critical && exc_vector == VEC_WDOG)
    else $error("watchdog entry wrong");
  a_wdog_save_regs: assert property (take_wdog |=> save_restore_2 == $past(next_insn_addr) && save_restore_3 == $past(msr_out)
    && save_restore_0 == $past(save_restore_0) && exception_syndrome_reg == $past(exception_syndrome_reg) && data_fault_address_reg == $past(data_fault_address_reg))
    else $error("watchdog save registers wrong");
  a_wdog_msr_clear: assert property (take_wdog |=> (msr_out & MSR_CR_CLR) == 32'h0 &&
    msr_out[MSR_ME] == $past(msr_out[MSR_ME]))
    else $error("critical state update wrong");
  a_tsr_other_bits: assert property (!(apb_wr && hit_tsr) |=> (timer_status_reg & ~TSR_FLAGS) == ($past(timer_status_reg) & ~TSR_FLAGS))
    else $error("status bits changed by a time-out");
  a_dtlb_entry_vec: assert property (dacc.valid && msr_out[MSR_DR] && !(|tlb_hit) |=>
    exc_take && !exc_critical && exc_vector == VEC_DTLB)
    else $error("data miss not taken");
  a_dtlb_save_regs: assert property (take_dtlb |=> save_restore_0 == $past(dacc.insn_addr) &&
    data_fault_address_reg == $past(dacc.addr) &&
    exception_syndrome_reg == (($past(exception_syndrome_reg) & (32'h1 << ESR_MCI)) | ({31'h0, $past(dacc.store_like)} << ESR_DST)))
    else $error("data miss save registers wrong");
  // end-to-end timing, masking and the bus answer
  a_fit_chain: assert property (fit_edge ##1 s_fit_enabled |=> exc_take && exc_vector == VEC_FIT)
    else $error("fixed-interval entry not raised after flag");
  a_fit_masked: assert property (!(timer_control_reg[TCR_FIE] && msr_out[MSR_EE]) && !take_dtlb && !take_wdog |=>
    !exc_take)
    else $error("fixed-interval entry while masked");
  a_wdog_chain: assert property (s_wdog_arm ##2 s_wdog_enabled |=>
    exc_take && exc_critical && exc_vector == VEC_WDOG)
    else $error("watchdog entry late or missing");
  a_wdog_no_arm: assert property (wd_edge && !timer_status_reg[TSR_ENW] |=> !wdog_det)
    else $error("watchdog detected while not armed");
  a_wdog_masked: assert property (!(timer_control_reg[TCR_WIE] && msr_out[MSR_CE]) |=> !exc_critical)
    else $error("watchdog entry while masked");
  a_dtlb_hit_quiet: assert property (dacc.valid && (|tlb_hit) && !take_wdog && !take_fit |=> !exc_take)
    else $error("entry raised on a translation hit");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  a_apb_ready_pulse: assert property (pready |=> !pready)
    else $error("apb ready held too long");
  a_apb_err_data: assert property (psel && penable && !pready && !addr_ok |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

`default_nettype wire

/* tb.sv */
// self-checking testbench for the timer and data-miss exception entry
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tde_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic exc_take, exc_critical;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, time_base, next_insn_addr, msr_out;
  logic [15:0] exc_vector, vec_seen;
  logic crit_seen;
  tde_dacc_t dacc;
  int errors = 0;
  int checks_done = 0;
  // design under test
  tde_exception_entry #(.TLB_N(64)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_base(time_base), .next_insn_addr(next_insn_addr), .dacc(dacc), .exc_take(exc_take),
    .exc_critical(exc_critical), .exc_vector(exc_vector), .msr_out(msr_out));
  // 250 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(nm, r, e);
  endtask
  // watch for an entry pulse over a few cycles, then judge it
  task automatic expect_exc(input string nm, input logic t, input logic [15:0] v, input logic c);
    logic s;
    s = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      if (exc_take === 1'b1 && !s) begin
        s = 1'b1;
        vec_seen = exc_vector;
        crit_seen = exc_critical;
      end
    end
    chk(nm, {31'h0, s}, {31'h0, t});
    if (t) begin
      chk("vector", {16'h0, vec_seen}, {16'h0, v});
      chk("critical", {31'h0, crit_seen}, {31'h0, c});
    end
  endtask
  task automatic tbit(input int i, input logic v);
    @(posedge pclk);
    time_base[i] <= v;
  endtask
  // reset state and an unmapped access
  task automatic t_reset();
    logic [31:0] r;
    logic er;
    chk("vector after reset", {16'h0, exc_vector}, 32'h1010);
    chk("msr after reset", msr_out, 32'h0);
    rc("tsr after reset", OFF_TSR, 32'h0);
    apb(1'b0, 8'h30, 32'h0, r, er);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask
  // fixed interval: masked, then taken on a fresh edge
  task automatic t_fit();
    logic [31:0] m;
    m = (32'h1 << MSR_EE) | (32'h1 << MSR_CE) | (32'h1 << MSR_ME) | (32'h1 << MSR_DE) | (32'h1 << MSR_PR) | 32'h20;
    wr(OFF_TSR, 32'h8000_0000);
    wr(OFF_MSR, m);
    next_insn_addr <= 32'h0000_4440;
    tbit(FIT_TB_BASE, 1'b1);
    expect_exc("fit masked", 1'b0, 16'h0, 1'b0);
    rc("tsr fit flag", OFF_TSR, 32'h8400_0000);
    tbit(FIT_TB_BASE, 1'b0);
    wr(OFF_TSR, 32'h8400_0000);
    wr(OFF_TCR, 32'h1 << TCR_FIE);
    tbit(FIT_TB_BASE, 1'b1);
    expect_exc("fit taken", 1'b1, 16'h1010, 1'b0);
    chk("fit msr", msr_out, m & ~MSR_NC_CLR);
    rc("fit save_restore_0", OFF_SAVE_RESTORE_0, 32'h0000_4440);
    rc("fit save_restore_1", OFF_SAVE_RESTORE_1, m);
    rc("fit save_restore_3", OFF_SAVE_RESTORE_3, 32'h0);
    rc("fit tsr", OFF_TSR, 32'h8400_0000);
  endtask
  // watchdog: taken once, gated by enable and arm
  task automatic t_wdog();
    logic [31:0] m;
    m = (32'h1 << MSR_EE) | (32'h1 << MSR_CE) | (32'h1 << MSR_ME) | (32'h1 << MSR_DE) | (32'h1 << MSR_FP);
    wr(OFF_TSR, 32'h8400_0000);
    wr(OFF_TCR, 32'h1 << TCR_WIE);
    wr(OFF_MSR, m);
    next_insn_addr <= 32'h0000_5550;
    tbit(WDOG_TB_BASE, 1'b1);
    expect_exc("wdog taken", 1'b1, 16'h1020, 1'b1);
    chk("wdog msr", msr_out, m & ~MSR_CR_CLR);
    rc("wdog save_restore_2", OFF_SAVE_RESTORE_2, 32'h0000_5550);
    rc("wdog save_restore_3", OFF_SAVE_RESTORE_3, m);
    rc("wdog save_restore_0", OFF_SAVE_RESTORE_0, 32'h0000_4440);
    rc("wdog tsr", OFF_TSR, 32'hc000_0000);
    tbit(WDOG_TB_BASE, 1'b0);
    tbit(WDOG_TB_BASE, 1'b1);
    expect_exc("wdog again", 1'b0, 16'h0, 1'b0);
    wr(OFF_TSR, 32'h4000_0000);
    wr(OFF_MSR, m);
    tbit(WDOG_TB_BASE, 1'b0);
    tbit(WDOG_TB_BASE, 1'b1);
    expect_exc("wdog unarmed", 1'b0, 16'h0, 1'b0);
    rc("tsr unarmed", OFF_TSR, 32'h0);
    wr(OFF_TCR, 32'h0);
    wr(OFF_TSR, 32'h8000_0000);
    tbit(WDOG_TB_BASE, 1'b0);
    tbit(WDOG_TB_BASE, 1'b1);
    expect_exc("wdog disabled", 1'b0, 16'h0, 1'b0);
    rc("tsr disabled", OFF_TSR, 32'hc000_0000);
    wr(OFF_TSR, 32'h4000_0000);
  endtask
  // period code 1 moves both time-outs four time-base bits up
  task automatic t_period();
    wr(OFF_TSR, 32'h8000_0000);
    wr(OFF_TCR, (32'h1 << TCR_FP) | (32'h1 << TCR_WP));
    tbit(FIT_TB_BASE, 1'b0);
    tbit(FIT_TB_BASE, 1'b1);
    tbit(WDOG_TB_BASE, 1'b0);
    tbit(WDOG_TB_BASE, 1'b1);
    rc("tsr old bits", OFF_TSR, 32'h8000_0000);
    tbit(FIT_TB_BASE + TB_STEP, 1'b1);
    tbit(WDOG_TB_BASE + TB_STEP, 1'b1);
    rc("tsr new bits", OFF_TSR, 32'hc400_0000);
    wr(OFF_TSR, 32'h4400_0000);
    wr(OFF_TCR, 32'h0);
  endtask
  // data translation: hit, store miss, gated miss, load miss
  task automatic t_dmiss();
    logic [31:0] m;
    m = (32'h1 << MSR_DR) | (32'h1 << MSR_EE) | (32'h1 << MSR_ME);
    wr(OFF_PID, 32'h5a);
    wr(OFF_TLB_IDX, 32'h0);
    wr(OFF_TLB_DATA, 32'h85a1_2345);
    rc("tlb word", OFF_TLB_DATA, 32'h85a1_2345);
    rc("process id", OFF_PID, 32'h0000_005a);
    wr(OFF_ESR, 32'h8000_00ff);
    wr(OFF_MSR, m);
    dacc <= '{1'b1, 1'b1, 32'h0000_7000, 32'h1234_5678};
    expect_exc("tlb hit", 1'b0, 16'h0, 1'b0);
    dacc <= '{1'b1, 1'b1, 32'h0000_7000, 32'h1234_6000};
    expect_exc("store miss", 1'b1, 16'h1100, 1'b0);
    dacc.valid <= 1'b0;
    rc("miss save_restore_0", OFF_SAVE_RESTORE_0, 32'h0000_7000);
    rc("miss data_fault_address_reg", OFF_DATA_FAULT_ADDRESS_REG, 32'h1234_6000);
    rc("miss esr", OFF_ESR, 32'h8080_0000);
    rc("miss save_restore_1", OFF_SAVE_RESTORE_1, m);
    chk("miss msr", msr_out, m & ~MSR_NC_CLR);
    wr(OFF_PID, 32'h5b);
    dacc <= '{1'b1, 1'b0, 32'h0000_7100, 32'h1234_5000};
    expect_exc("miss gated", 1'b0, 16'h0, 1'b0);
    wr(OFF_MSR, m);
    expect_exc("load miss", 1'b1, 16'h1100, 1'b0);
    dacc.valid <= 1'b0;
    rc("load esr", OFF_ESR, 32'h8000_0000);
    rc("load data_fault_address_reg", OFF_DATA_FAULT_ADDRESS_REG, 32'h1234_5000);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    time_base = 32'h0;
    next_insn_addr = 32'h0;
    dacc = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fit();
    t_wdog();
    t_period();
    t_dmiss();
    print_verdict();
  end
endmodule
`default_nettype wire
